// *** pse_port_map.svh ***
/*
 register offsets, field positions, reset values, codes and timing counts
 for the four-port power state and operating mode block.
 assumes inclusion by bare name from the power state module, the device model, the checker and the testbench.
*/
`ifndef PSE_PORT_MAP_SVH
`define PSE_PORT_MAP_SVH
`define PWR_STATE_ADDR 8'h10
`define OP_SELECT_ADDR 8'h12
`define DET_CLS_EN_ADDR 8'h14
`define PWR_STATE_RESET 8'h00
`define OP_SELECT_RESET 8'h00
`define DET_CLS_EN_RESET 8'h00
`define OK_FIELD_LSB 4
`define ON_FIELD_LSB 0
`define CLS_EN_LSB 4
`define DET_EN_LSB 0
`define DET_VALID 4'h4
`define DET_CAP 4'h2
`define DET_XPSE 4'h7
`define CLS_LIMITED4 4'hC
`define CLS_LEGACY5 4'hD
`define CLS_MISMATCH 4'hF
`define CLS_UNKNOWN 4'h0
`define INRUSH_WINDOW_US 60
`define CLK_MHZ 100
`define INRUSH_CYCLES (`INRUSH_WINDOW_US * `CLK_MHZ)
`endif

// *** pse_port_pkg.sv ***
/*
 types shared by the power state block.
 assumes the map header for numeric constants.
*/
package pse_port_pkg;
   typedef enum logic [1:0] {
      MODE_SHUTDOWN,
      MODE_MANUAL,
      MODE_HOST,
      MODE_AUTO
   } op_mode_t;
   typedef struct packed {
      logic [3:0] det_result;
      logic det_valid;
      logic cap_over;
      logic cross_pse;
   } det_in_t;
   typedef struct packed {
      logic [3:0] cls_result;
      logic cls_valid;
   } cls_in_t;
endpackage : pse_port_pkg

// *** pse_result_mem.sv ***
/*
 four-entry store of per-port class and detection results.
 assumes one writer per cycle; read data registered.
*/
`timescale 1ns/1ps
`default_nettype none
module pse_result_mem #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 8
) (
   input wire logic mclk_in, // clock
   input wire logic sys_rst_in, // sync reset
   input wire logic clk_en_in, // clock enable
   input wire logic wr_en_in, // write strobe
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_in, // write index
   input wire logic [WIDTH-1:0] wr_data_in, // write data
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_in, // read index
   output logic [WIDTH-1:0] rd_data_out // registered read data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] rd_d;
   // read mux
   always_comb begin
      rd_d = mem_q[rd_addr_in];
   end
   // storage and read register
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         rd_data_out <= '0;
      end else if (clk_en_in) begin
         if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= rd_d;
      end
   end
endmodule : pse_result_mem
`default_nettype wire

// *** pse_port_power_state_mode.sv ***
/*
 per-port power state and operating mode control for a four-port group:
 switch-on/powered-ok tracking, inrush timing, mode decode, class report filter.
 assumes a register access port (address, write, read data) decoded by the
 serial interface outside, and analogue measurement results as synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pse_port_map.svh"
module pse_port_power_state_mode
   import pse_port_pkg::*;
#(
   parameter int PORTS = 4,
   parameter int INRUSH_CYC = `INRUSH_CYCLES
) (
   input wire logic mclk_in, // 100 MHz clock
   input wire logic sys_rst_in, // sync reset, high
   input wire logic clk_en_in, // freezes all state when low
   input wire logic [7:0] reg_addr_in, // register address
   input wire logic reg_wr_in, // register write strobe
   input wire logic [7:0] reg_wdata_in, // register write data
   output logic [7:0] reg_rdata_out, // registered read data
   input wire logic group_reset_in, // group reset command
   input wire logic legacy5_sel_in, // legacy class 5 allocation selected
   input wire logic [PORTS-1:0] power_on_request_in, // power-on request pulses
   input wire logic [PORTS-1:0] power_off_request_in, // switch-off requests
   input wire logic [PORTS-1:0] drain_low_in, // drain within 2 V of ground
   input wire logic [PORTS-1:0] fault_in, // overcurrent/power-cut/disconnect
   input wire det_in_t [PORTS-1:0] det_in, // detection measurements
   input wire cls_in_t [PORTS-1:0] cls_in, // classification measurements
   output logic [PORTS-1:0] gate_drive_out, // switch gate drive
   output logic [PORTS-1:0] detect_run_out, // run detection on port
   output logic [PORTS-1:0] class_run_out, // run classification on port
   output logic [PORTS-1:0] class_reset_out, // class reset pulse
   output logic [PORTS-1:0] monitor_en_out, // fault monitoring enabled
   output logic [PORTS-1:0] switch_on_chg_out, // switch-on change pulse
   output logic [PORTS-1:0] powered_ok_chg_out, // powered-ok change pulse
   output logic [PORTS-1:0] class_complete_flag_out // fresh class result pulse
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_DETECT, ST_CLASS, ST_INRUSH, ST_POWERED
   } port_st_t;
   localparam int CW = $clog2(INRUSH_CYC + 1);

   port_st_t st_q [PORTS];
   port_st_t st_d [PORTS];
   logic [CW-1:0] cnt_q [PORTS];
   logic [CW-1:0] cnt_d [PORTS];
   logic [PORTS-1:0] on_q, on_d, ok_q, ok_d, pend_q, pend_d, pon_q, pon_d;
   logic [7:0] mode_q, mode_d, en_q, en_d;
   logic [PORTS-1:0] crst_d, crst_q, cdone_d, cdone_q, son_chg_d, pok_chg_d, son_chg_q, pok_chg_q;
   logic [1:0] svc_q, svc_d;
   logic mem_we;
   logic [1:0] mem_wa;
   logic [7:0] mem_wd;
   logic [7:0] mem_rd;
   logic [7:0] rdata_d;

   // port mode field of one port
   function automatic op_mode_t mode_of(input logic [7:0] m, input int p);
      mode_of = op_mode_t'(m[2*p +: 2]);
   endfunction

   // filter a raw class code against context
   function automatic logic [3:0] cls_filter(input logic [3:0] c, input logic pon, input logic l5);
      cls_filter = c;
      if (c == `CLS_LIMITED4 && !pon) begin
         cls_filter = 4'h4;
      end
      if (c == `CLS_LEGACY5 && !l5) begin
         cls_filter = `CLS_UNKNOWN;
      end
   endfunction

   // detection code from measurements
   function automatic logic [3:0] det_code(input det_in_t d);
      det_code = d.det_result;
      if (d.cap_over) begin
         det_code = `DET_CAP;
      end
      if (d.cross_pse) begin
         det_code = `DET_XPSE;
      end
   endfunction

   // mode and enable register next values
   always_comb begin
      mode_d = mode_q;
      en_d = en_q;
      if (reg_wr_in && reg_addr_in == `OP_SELECT_ADDR) begin
         mode_d = reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `DET_CLS_EN_ADDR) begin
         en_d = reg_wdata_in;
      end
      if (group_reset_in) begin
         mode_d = `OP_SELECT_RESET;
      end
      for (int p = 0; p < PORTS; p++) begin
         if (mode_of(mode_d, p) == MODE_SHUTDOWN) begin
            en_d[`CLS_EN_LSB + p] = 1'b0;
            en_d[`DET_EN_LSB + p] = 1'b0;
         end
      end
   end

   // per-port sequencer next state; one port serviced at a time for detection and classification
   always_comb begin
      svc_d = svc_q;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      on_d = on_q;
      ok_d = ok_q;
      pend_d = pend_q;
      pon_d = pon_q;
      crst_d = '0;
      cdone_d = '0;
      for (int p = 0; p < PORTS; p++) begin
         st_d[p] = st_q[p];
         cnt_d[p] = cnt_q[p];
         if (power_on_request_in[p]) begin
            pend_d[p] = 1'b1;
         end
         if (mode_of(mode_q, p) == MODE_AUTO && en_q[`CLS_EN_LSB + p] && en_q[`DET_EN_LSB + p]) begin
            pend_d[p] = 1'b1;
         end
         case (st_q[p])
            ST_IDLE: begin
               if (mode_of(mode_q, p) != MODE_SHUTDOWN && (pend_q[p] ||
                   (mode_of(mode_q, p) == MODE_HOST && en_q[`DET_EN_LSB + p]))) begin
                  st_d[p] = ST_DETECT;
                  pon_d[p] = pend_q[p];
                  pend_d[p] = power_on_request_in[p];
               end
            end
            ST_DETECT: begin
               if (pend_q[p]) begin
                  pon_d[p] = 1'b1;
                  pend_d[p] = power_on_request_in[p];
               end
               if (det_in[p].det_valid && svc_q == 2'(p)) begin
                  mem_we = 1'b1;
                  mem_wa = 2'(p);
                  mem_wd = {4'h0, det_code(det_in[p])};
                  if (det_code(det_in[p]) == `DET_VALID &&
                      (pon_q[p] || en_q[`CLS_EN_LSB + p])) begin
                     st_d[p] = ST_CLASS;
                  end else if (!pon_q[p] && !en_q[`DET_EN_LSB + p]) begin
                     st_d[p] = ST_IDLE;
                  end
               end
            end
            ST_CLASS: begin
               if (cls_in[p].cls_valid && svc_q == 2'(p)) begin
                  if (cls_in[p].cls_result == `CLS_MISMATCH) begin
                     crst_d[p] = 1'b1;
                  end else begin
                     mem_we = 1'b1;
                     mem_wa = 2'(p);
                     mem_wd = {cls_filter(cls_in[p].cls_result, pon_q[p], legacy5_sel_in), `DET_VALID};
                     cdone_d[p] = 1'b1;
                     if (pon_q[p]) begin
                        st_d[p] = ST_INRUSH;
                        on_d[p] = 1'b1;
                        cnt_d[p] = CW'(INRUSH_CYC);
                     end else begin
                        st_d[p] = ST_DETECT;
                     end
                  end
               end
            end
            ST_INRUSH: begin
               if (cnt_q[p] != '0) begin
                  cnt_d[p] = cnt_q[p] - CW'(1);
               end else if (drain_low_in[p]) begin
                  st_d[p] = ST_POWERED;
                  ok_d[p] = 1'b1;
               end else begin
                  st_d[p] = ST_IDLE;
                  on_d[p] = 1'b0;
               end
            end
            ST_POWERED: begin
               if (fault_in[p]) begin
                  st_d[p] = ST_IDLE;
               end
            end
            default: st_d[p] = ST_IDLE;
         endcase
         if (mode_of(mode_d, p) == MODE_SHUTDOWN || power_off_request_in[p] ||
             (st_q[p] == ST_POWERED && fault_in[p])) begin
            st_d[p] = ST_IDLE;
            on_d[p] = 1'b0;
            ok_d[p] = 1'b0;
            pon_d[p] = 1'b0;
            if (mode_of(mode_d, p) == MODE_SHUTDOWN) begin
               pend_d[p] = 1'b0;
            end
         end
      end
      // rotate service slot across ports
      svc_d = svc_q + 2'd1;
      son_chg_d = on_d ^ on_q;
      pok_chg_d = ok_d ^ ok_q;
   end

   // state registers
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         for (int p = 0; p < PORTS; p++) begin
            st_q[p] <= ST_IDLE;
            cnt_q[p] <= '0;
         end
         on_q <= '0;
         ok_q <= '0;
         pend_q <= '0;
         pon_q <= '0;
         mode_q <= `OP_SELECT_RESET;
         en_q <= `DET_CLS_EN_RESET;
         svc_q <= '0;
         crst_q <= '0;
         cdone_q <= '0;
         son_chg_q <= '0;
         pok_chg_q <= '0;
         reg_rdata_out <= '0;
      end else if (clk_en_in) begin
         for (int p = 0; p < PORTS; p++) begin
            st_q[p] <= st_d[p];
            cnt_q[p] <= cnt_d[p];
         end
         on_q <= on_d;
         ok_q <= ok_d;
         pend_q <= pend_d;
         pon_q <= pon_d;
         mode_q <= mode_d;
         en_q <= en_d;
         svc_q <= svc_d;
         crst_q <= crst_d;
         cdone_q <= cdone_d;
         son_chg_q <= son_chg_d;
         pok_chg_q <= pok_chg_d;
         reg_rdata_out <= rdata_d;
      end
   end

   // read mux
   always_comb begin
      case (reg_addr_in)
         `PWR_STATE_ADDR: rdata_d = {ok_q, on_q};
         `OP_SELECT_ADDR: rdata_d = mode_q;
         `DET_CLS_EN_ADDR: rdata_d = en_q;
         8'h0C, 8'h0D, 8'h0E, 8'h0F: rdata_d = mem_rd;
         default: rdata_d = 8'h00;
      endcase
   end

   pse_result_mem #(.DEPTH(4), .WIDTH(8)) u_results (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .wr_en_in(mem_we),
      .wr_addr_in(mem_wa),
      .wr_data_in(mem_wd),
      .rd_addr_in(reg_addr_in[1:0]),
      .rd_data_out(mem_rd)
   );

   // outputs
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         detect_run_out[p] = (st_q[p] == ST_DETECT);
         class_run_out[p] = (st_q[p] == ST_CLASS);
         monitor_en_out[p] = (st_q[p] == ST_POWERED);
      end
   end
   assign gate_drive_out = on_q;
   assign class_reset_out = crst_q;
   assign class_complete_flag_out = cdone_q;
   assign switch_on_chg_out = son_chg_q;
   assign powered_ok_chg_out = pok_chg_q;
endmodule : pse_port_power_state_mode
`default_nettype wire

// *** pse_pd_model.sv ***
/*
 behavioural powered devices on four ports: each answers a detection or
 classification run with the codes that the bench sets.
 assumes run requests are held until the block takes a result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pse_port_map.svh"
module pse_pd_model
   import pse_port_pkg::*;
(
   input wire logic mclk_in, // clock
   input wire logic [3:0] detect_run_in, // detection running
   input wire logic [3:0] class_run_in, // classification running
   input wire logic [3:0] det_code_in, // detection answer
   input wire logic [3:0] cls_code_in, // class answer
   output var det_in_t [3:0] det_out, // detection measurement
   output var cls_in_t [3:0] cls_out // class measurement
);
   logic [3:0] raw_code;
   // capacitive and cross-connected loads give no plain code; only the flags carry them
   assign raw_code = (det_code_in == `DET_CAP || det_code_in == `DET_XPSE) ? 4'h0 : det_code_in;
   // answers while a run is on; an idle line shows the inverted code
   always_ff @(posedge mclk_in) begin
      for (int i = 0; i < 4; i++) begin
         det_out[i] <= '{detect_run_in[i] ? raw_code : ~raw_code, detect_run_in[i],
            det_code_in == `DET_CAP, det_code_in == `DET_XPSE};
         cls_out[i] <= '{class_run_in[i] ? cls_code_in : ~cls_code_in, class_run_in[i]};
      end
   end
endmodule : pse_pd_model
`default_nettype wire

// *** pse_port_power_state_mode_chk.sv ***
/*
 port checker for the power state block.
 assumes the clock enable is held high; bound at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pse_port_map.svh"
module pse_port_power_state_mode_chk #(
   parameter int PORTS = 4,
   parameter int INRUSH_CYC = 8
) (
   input wire logic mclk_in, // clock
   input wire logic sys_rst_in, // sync reset
   input wire logic [7:0] reg_addr_in, // address
   input wire logic reg_wr_in, // write strobe
   input wire logic [7:0] reg_wdata_in, // write data
   input wire logic [7:0] reg_rdata_out, // read data
   input wire logic group_reset_in, // group reset
   input wire logic [PORTS-1:0] drain_low_in, // drain low
   input wire logic [PORTS-1:0] gate_drive_out, // gate drive
   input wire logic [PORTS-1:0] detect_run_out, // detecting
   input wire logic [PORTS-1:0] class_run_out, // classifying
   input wire logic [PORTS-1:0] class_reset_out, // class reset
   input wire logic [PORTS-1:0] monitor_en_out, // monitoring
   input wire logic [PORTS-1:0] switch_on_chg_out, // on change
   input wire logic [PORTS-1:0] powered_ok_chg_out // ok change
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   logic run_q;
   logic run2_q;
   // history of reset so that past values never reach into it
   always_ff @(posedge mclk_in) begin
      run_q <= !sys_rst_in;
      run2_q <= run_q;
   end
   AST_ON_CHG: assert property (run_q && run2_q |->
      switch_on_chg_out == (gate_drive_out ^ $past(gate_drive_out))) else $error("on change pulse wrong");
   AST_OK_CHG: assert property (run_q && run2_q |->
      powered_ok_chg_out == (monitor_en_out ^ $past(monitor_en_out))) else $error("ok change pulse wrong");
   AST_OK_NEEDS_ON: assert property ((monitor_en_out & ~gate_drive_out) == '0)
      else $error("monitoring without gate");
   AST_OK_RISE: assert property (run_q |-> (monitor_en_out & ~$past(monitor_en_out) &
      ~($past(gate_drive_out) & $past(drain_low_in))) == '0) else $error("ok without low drain");
   AST_ON_RISE: assert property (run_q |->
      (gate_drive_out & ~$past(gate_drive_out) & ~$past(class_run_out)) == '0) else $error("gate before class");
   AST_CLS_RISE: assert property (run_q |->
      (class_run_out & ~$past(class_run_out) & ~$past(detect_run_out)) == '0) else $error("class before detect");
   AST_CRST_CAUSE: assert property (run_q |-> (class_reset_out & ~$past(class_run_out)) == '0)
      else $error("class reset outside class");
   AST_CRST_PULSE: assert property (class_reset_out != '0 |=> (class_reset_out & $past(class_reset_out)) == '0)
      else $error("class reset too long");
   AST_STATE_READ: assert property (run_q && $past(reg_addr_in) == `PWR_STATE_ADDR |->
      reg_rdata_out == {$past(monitor_en_out), $past(gate_drive_out)}) else $error("state read wrong");
   AST_GROUP_RST: assert property (run2_q && $past(group_reset_in, 2) && $past(group_reset_in) &&
      $past(reg_addr_in) == `OP_SELECT_ADDR |-> reg_rdata_out == 8'h00) else $error("mode not cleared");
   AST_SHUTDOWN: assert property (reg_wr_in && reg_addr_in == `OP_SELECT_ADDR && reg_wdata_in == 8'h00 |->
      ##[1:3] (gate_drive_out == '0 && monitor_en_out == '0)) else $error("shutdown left port on");
endmodule : pse_port_power_state_mode_chk
bind pse_port_power_state_mode pse_port_power_state_mode_chk #(.PORTS(PORTS), .INRUSH_CYC(INRUSH_CYC))
   i_pse_port_power_state_mode_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .group_reset_in(group_reset_in), .drain_low_in(drain_low_in), .gate_drive_out(gate_drive_out),
   .detect_run_out(detect_run_out), .class_run_out(class_run_out), .class_reset_out(class_reset_out),
   .monitor_en_out(monitor_en_out), .switch_on_chg_out(switch_on_chg_out),
   .powered_ok_chg_out(powered_ok_chg_out));
`default_nettype wire

// *** test_pse_port_power_state_mode.sv ***
/*
 testbench for the power state block: register tasks and port sequences.
 assumes the device model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pse_port_map.svh"
module test_pse_port_power_state_mode
   import pse_port_pkg::*;
;
   logic mclk_in, sys_rst_in, reg_wr_in, group_reset_in, legacy5_sel_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [3:0] pon, poff, drain, gate, det_run, cls_run, cls_rst, mon, on_chg, ok_chg, done, det_code, cls_code;
   logic [3:0] fault;
   det_in_t [3:0] det;
   cls_in_t [3:0] cls;
   int failures, samples_checked;
   // free running clock
   initial begin
      mclk_in = 1'h0;
      forever #5 mclk_in = ~mclk_in;
   end
   pse_port_power_state_mode #(.INRUSH_CYC(8)) i_pse_port_power_state_mode (.mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in), .clk_en_in(1'h1), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .group_reset_in(group_reset_in),
      .legacy5_sel_in(legacy5_sel_in), .power_on_request_in(pon), .power_off_request_in(poff),
      .drain_low_in(drain), .fault_in(fault), .det_in(det), .cls_in(cls), .gate_drive_out(gate),
      .detect_run_out(det_run), .class_run_out(cls_run), .class_reset_out(cls_rst), .monitor_en_out(mon),
      .switch_on_chg_out(on_chg), .powered_ok_chg_out(ok_chg), .class_complete_flag_out(done));
   pse_pd_model i_pse_pd_model (.mclk_in(mclk_in), .detect_run_in(det_run), .class_run_in(cls_run),
      .det_code_in(det_code), .cls_code_in(cls_code), .det_out(det), .cls_out(cls));
   task automatic give_verdict;
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'h1;
      tick(1);
      reg_wr_in = 1'h0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr_in = a;
      tick(3);
      samples_checked++;
      if (reg_rdata_out !== e) begin
         failures++;
         $display("ERROR reg %h expected %h seen %h", a, e, reg_rdata_out);
      end
   endtask : rd
   // bounded wait on gate (0), monitoring (1), class complete (2) or class reset (3)
   task automatic wt(input int s, input int p);
      int k;
      for (k = 0; k < 300; k++) begin
         if ({cls_rst[p], done[p], mon[p], gate[p]} >> s & 4'h1) break;
         tick(1);
      end
      samples_checked++;
      if (k == 300) begin
         failures++;
         $display("ERROR wait %0d port %0d expected 1 seen 0", s, p);
         give_verdict();
      end
   endtask : wt
   task automatic pulse_on(input logic [3:0] m);
      pon = m;
      tick(1);
      pon = 4'h0;
   endtask : pulse_on
   // main sequence
   initial begin
      failures = 0;
      samples_checked = 0;
      {sys_rst_in, reg_wr_in, group_reset_in, legacy5_sel_in} = 4'h8;
      {reg_addr_in, reg_wdata_in} = 16'h0000;
      {pon, poff, drain, fault} = 16'h00F0;
      det_code = `DET_VALID;
      cls_code = `CLS_LEGACY5;
      tick(16);
      sys_rst_in = 1'h0;
      rd(`PWR_STATE_ADDR, `PWR_STATE_RESET);
      rd(`OP_SELECT_ADDR, `OP_SELECT_RESET);
      rd(8'h55, 8'h00);
      wr(`OP_SELECT_ADDR, 8'h1B);
      rd(`OP_SELECT_ADDR, 8'h1B);
      wr(`OP_SELECT_ADDR, 8'hAA);
      wr(`DET_CLS_EN_ADDR, 8'hFF);
      wt(2, 1);
      rd(8'h0D, {`CLS_UNKNOWN, `DET_VALID});
      legacy5_sel_in = 1'h1;
      wt(2, 1);
      rd(8'h0D, {`CLS_LEGACY5, `DET_VALID});
      cls_code = `CLS_LIMITED4;
      wt(2, 1);
      rd(8'h0D, {4'h4, `DET_VALID});
      cls_code = `CLS_MISMATCH;
      wt(3, 1);
      cls_code = 4'h1;
      pulse_on(4'h1);
      wt(0, 0);
      rd(`PWR_STATE_ADDR, 8'h01);
      wt(1, 0);
      rd(`PWR_STATE_ADDR, 8'h11);
      drain = 4'hD;
      pulse_on(4'h2);
      wt(0, 1);
      tick(30);
      rd(`PWR_STATE_ADDR, 8'h11);
      poff = 4'h1;
      tick(2);
      poff = 4'h0;
      rd(`PWR_STATE_ADDR, 8'h00);
      det_code = `DET_CAP;
      tick(12);
      rd(8'h0C, {4'h0, `DET_CAP});
      det_code = `DET_XPSE;
      tick(12);
      rd(8'h0C, {4'h0, `DET_XPSE});
      det_code = `DET_VALID;
      drain = 4'hF;
      pulse_on(4'h4);
      wt(0, 2);
      fault = 4'h4;
      tick(3);
      fault = 4'h0;
      wt(1, 2);
      fault = 4'h4;
      tick(1);
      fault = 4'h0;
      rd(`PWR_STATE_ADDR, 8'h00);
      pulse_on(4'h4);
      wt(0, 2);
      wr(`OP_SELECT_ADDR, 8'h00);
      rd(`PWR_STATE_ADDR, 8'h00);
      wr(`OP_SELECT_ADDR, 8'hAA);
      group_reset_in = 1'h1;
      tick(2);
      group_reset_in = 1'h0;
      rd(`OP_SELECT_ADDR, 8'h00);
      give_verdict();
   end
endmodule : test_pse_port_power_state_mode
`default_nettype wire
